// file: inc/dac_pkg.sv
// shared constants and types for the converter front end and its data source
package dac_pkg;
    localparam int SAMPLE_W = 10;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_TIME_US = 50;
    localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 10;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 10'h000;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_MAX = WAKE_CNT_W'(WAKE_CYCLES - 1);

    typedef enum logic [3:0] {
        MODE_SHUTDOWN = 4'h1,
        MODE_STANDBY = 4'h2,
        MODE_WAKING = 4'h4,
        MODE_ACTIVE = 4'h8
    } mode_t;
endpackage

// file: inc/dac_link_if.sv
// link between data source and converter front end
`timescale 1ns/100ps
interface dac_link_if;
    logic [dac_pkg::SAMPLE_W-1:0] sample;
    logic power_down_select;
    logic converter_enable;
    logic reference_enable_n;

    modport converter (
        input sample,
        input power_down_select,
        input converter_enable,
        input reference_enable_n
    );
    modport source (
        output sample,
        output power_down_select,
        output converter_enable,
        output reference_enable_n
    );
endinterface

// file: core/dac_converter.sv
// converter front end: sample path and power mode control
`timescale 1ns/100ps
// What this block does
// RULE_01: capture latch then converter register drives array
// RULE_02: capture whole word every rising edge
// RULE_03: output follows one clock after capture
// RULE_04: ten-bit parallel word, one per clock
// RULE_05: source keeps clock at most 40MHz
// RULE_06: both selects low gives standby, outputs off
// RULE_07: enable high leaves standby after 50us
// RULE_08: power-down high gives shutdown, all off
// RULE_09: shutdown exit needs 50us to settle
// RULE_10: wake-up resumes last value before standby
// RULE_11: low reference enable selects internal reference
module dac_converter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    dac_link_if.converter link,
    // analog array control
    output logic [dac_pkg::SAMPLE_W-1:0] array_code,
    output logic array_enable,
    output logic output_drive_en,
    output logic reference_on,
    output logic amplifier_on,
    output logic internal_reference_sel,
    output logic settled,
    output dac_pkg::mode_t mode
);
    logic [dac_pkg::SAMPLE_W-1:0] capture_q;
    logic [dac_pkg::SAMPLE_W-1:0] convert_q;
    logic pd_meta_q, pd_q, en_meta_q, en_q, ren_meta_q, ren_q;
    dac_pkg::mode_t mode_q;
    dac_pkg::mode_t mode_d;
    logic [dac_pkg::WAKE_CNT_W-1:0] wake_cnt_q;

    // mode decoding shared by the output flops
    function automatic logic drives_array(input dac_pkg::mode_t m);
        return (m == dac_pkg::MODE_WAKING) || (m == dac_pkg::MODE_ACTIVE);
    endfunction

    function automatic logic keeps_reference(input dac_pkg::mode_t m);
        return (m != dac_pkg::MODE_SHUTDOWN);
    endfunction

    // ------------------------------------------------------------
    // control pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_meta_q <= 1'b1;
            pd_q <= 1'b1;
            en_meta_q <= 1'b0;
            en_q <= 1'b0;
            ren_meta_q <= 1'b0;
            ren_q <= 1'b0;
        end else begin
            pd_meta_q <= link.power_down_select;
            pd_q <= pd_meta_q;
            en_meta_q <= link.converter_enable;
            en_q <= en_meta_q;
            ren_meta_q <= link.reference_enable_n;
            ren_q <= ren_meta_q;
        end
    end

    // ------------------------------------------------------------
    // sample path
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_q <= dac_pkg::SAMPLE_RST;
        end else begin
            capture_q <= link.sample; // RULE_02 RULE_04
        end
    end

    // converter register holds while powered down
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convert_q <= dac_pkg::SAMPLE_RST;
        end else if (mode_q == dac_pkg::MODE_ACTIVE) begin
            convert_q <= capture_q; // RULE_01 RULE_03 RULE_10
        end
    end

    // ------------------------------------------------------------
    // power mode
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        if (pd_q) begin
            mode_d = dac_pkg::MODE_SHUTDOWN; // RULE_08
        end else if (!en_q) begin
            mode_d = dac_pkg::MODE_STANDBY; // RULE_06
        end else begin
            case (mode_q)
                dac_pkg::MODE_SHUTDOWN: mode_d = dac_pkg::MODE_WAKING; // RULE_09
                dac_pkg::MODE_STANDBY: mode_d = dac_pkg::MODE_WAKING; // RULE_07
                dac_pkg::MODE_WAKING: begin
                    if (wake_cnt_q == dac_pkg::WAKE_CNT_MAX) begin
                        mode_d = dac_pkg::MODE_ACTIVE;
                    end
                end
                dac_pkg::MODE_ACTIVE: mode_d = dac_pkg::MODE_ACTIVE;
                default: mode_d = dac_pkg::MODE_SHUTDOWN;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= dac_pkg::MODE_SHUTDOWN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // settling count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_cnt_q <= '0;
        end else if (mode_q == dac_pkg::MODE_WAKING) begin
            wake_cnt_q <= wake_cnt_q + 1'b1; // RULE_07 RULE_09
        end else begin
            wake_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // converter register drives the array directly: one clock latency
    assign array_code = convert_q; // RULE_01 RULE_03

    // current array and output stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            array_enable <= 1'b0;
            output_drive_en <= 1'b0;
        end else begin
            array_enable <= drives_array(mode_d); // RULE_06
            output_drive_en <= drives_array(mode_d); // RULE_10
        end
    end

    // reference and control amplifier
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reference_on <= 1'b0;
            amplifier_on <= 1'b0;
            internal_reference_sel <= 1'b0;
        end else begin
            reference_on <= keeps_reference(mode_d); // RULE_08
            amplifier_on <= keeps_reference(mode_d);
            internal_reference_sel <= !ren_q && keeps_reference(mode_d); // RULE_11
        end
    end

    // status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settled <= 1'b0;
            mode <= dac_pkg::MODE_SHUTDOWN;
        end else begin
            settled <= (mode_d == dac_pkg::MODE_ACTIVE);
            mode <= mode_d;
        end
    end
endmodule

// file: core/dac_fifo.sv
// sample buffer between producer logic and the link
`timescale 1ns/100ps
module dac_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// file: core/dac_source.sv
// data source end: buffered samples and mode pins onto the link
`timescale 1ns/100ps
module dac_source (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user sample stream
    input wire logic sample_valid,
    input wire logic [dac_pkg::SAMPLE_W-1:0] sample_data,
    output logic sample_ready,
    // user mode requests
    input wire logic shutdown_req,
    input wire logic run_req,
    input wire logic external_ref_req,
    output logic underrun,
    // link
    dac_link_if.source link
);
    logic fifo_valid;
    logic [dac_pkg::SAMPLE_W-1:0] fifo_data;
    logic [dac_pkg::SAMPLE_W-1:0] sample_q;
    logic pd_q, en_q, ren_q, under_q;
    logic streaming;

    assign streaming = en_q && !pd_q;

    // ------------------------------------------------------------
    // buffer
    // ------------------------------------------------------------
    dac_fifo #(
        .WIDTH(dac_pkg::SAMPLE_W),
        .DEPTH(dac_pkg::FIFO_DEPTH)
    ) i_dac_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .in_ready(sample_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(streaming)
    );

    // ------------------------------------------------------------
    // one word per clock while running; repeat last on underrun
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_q <= dac_pkg::SAMPLE_RST;
            under_q <= 1'b0;
        end else begin
            if (streaming && fifo_valid) begin
                sample_q <= fifo_data; // RULE_04 RULE_05
            end
            under_q <= streaming && !fifo_valid;
        end
    end

    // mode pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_q <= 1'b1;
            en_q <= 1'b0;
            ren_q <= 1'b0;
        end else begin
            pd_q <= shutdown_req; // RULE_08 RULE_09
            en_q <= run_req && !shutdown_req; // RULE_06 RULE_07
            ren_q <= external_ref_req; // RULE_11
        end
    end

    assign link.sample = sample_q;
    assign link.power_down_select = pd_q;
    assign link.converter_enable = en_q;
    assign link.reference_enable_n = ren_q;
    assign underrun = under_q;
endmodule

// file: verif/dac_link_sva.sv
// link and converter output assertions
`timescale 1ns/100ps
module dac_link_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic [9:0] sample,
    input wire logic power_down_select,
    input wire logic converter_enable,
    input wire logic reference_enable_n,
    // converter side
    input wire logic [9:0] array_code,
    input wire logic output_drive_en,
    input wire logic internal_reference_sel,
    input wire dac_pkg::mode_t mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // wake length counter
    // ----
    logic [10:0] wake_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wake_q <= '0;
        else if (mode == dac_pkg::MODE_WAKING)
            wake_q <= wake_q + 11'h001;
        else
            wake_q <= '0;
    end
    a_shutdown_entry:
        assert property ($rose(power_down_select) |-> ##[1:4] mode == dac_pkg::MODE_SHUTDOWN) else $error("no shutdown");
    a_shutdown_off:
        assert property (mode == dac_pkg::MODE_SHUTDOWN |-> !output_drive_en && !internal_reference_sel)
        else $error("shutdown outputs on");
    a_standby_entry:
        assert property ((!power_down_select && !converter_enable)[*5] |-> mode == dac_pkg::MODE_STANDBY
            && !output_drive_en) else $error("no standby");
    a_wake_start:
        assert property ($rose(converter_enable) && !power_down_select |-> ##[1:5] mode == dac_pkg::MODE_WAKING)
        else $error("no wake");
    a_wake_length:
        assert property (mode == dac_pkg::MODE_ACTIVE && $past(mode) == dac_pkg::MODE_WAKING
            |-> wake_q + 1 >= dac_pkg::WAKE_CYCLES && wake_q <= dac_pkg::WAKE_CYCLES + 1) else $error("wake length");
    a_data_latency:
        assert property ((mode == dac_pkg::MODE_ACTIVE)[*4] |-> array_code == $past(sample, 2))
        else $error("data latency");
    a_idle_hold:
        assert property ((mode != dac_pkg::MODE_ACTIVE)[*3] |-> $stable(array_code)) else $error("code moved");
    a_ref_internal:
        assert property ((!power_down_select && !reference_enable_n)[*5] |-> internal_reference_sel)
        else $error("reference select");
    cover property (mode == dac_pkg::MODE_ACTIVE);
    cover property (mode == dac_pkg::MODE_STANDBY);
    cover property ($fell(power_down_select));
endmodule

// file: verif/dac_input_and_power_control_bench.sv
// self-checking bench for source, link and converter
`timescale 1ns/100ps
module dac_input_and_power_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    logic [9:0] sample_data = 10'h000;
    logic shutdown_req = 1'b1;
    logic run_req = 1'b0;
    logic external_ref_req = 1'b0;
    logic sample_ready, underrun, array_enable, output_drive_en;
    logic reference_on, amplifier_on, internal_reference_sel, settled;
    logic [9:0] array_code;
    dac_pkg::mode_t mode;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    dac_link_if link ();
    dac_source i_dac_source (.clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_ready(sample_ready), .shutdown_req(shutdown_req), .run_req(run_req),
        .external_ref_req(external_ref_req), .underrun(underrun), .link(link.source));
    dac_converter i_dac_converter (.clk(clk), .rst(rst), .link(link.converter), .array_code(array_code),
        .array_enable(array_enable), .output_drive_en(output_drive_en), .reference_on(reference_on),
        .amplifier_on(amplifier_on), .internal_reference_sel(internal_reference_sel), .settled(settled), .mode(mode));
    dac_link_sva i_dac_link_sva (.clk(clk), .rst(rst), .sample(link.sample), .power_down_select(link.power_down_select),
        .converter_enable(link.converter_enable), .reference_enable_n(link.reference_enable_n),
        .array_code(array_code), .output_drive_en(output_drive_en), .internal_reference_sel(internal_reference_sel),
        .mode(mode));
    // ----
    // helpers
    // ----
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_mode(input dac_pkg::mode_t m, output int n);
        n = 0;
        while (mode !== m && n < 1100) begin
            @(negedge clk);
            n++;
        end
        check(mode, m, "mode");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 9000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ----
    // scenarios
    // ----
    task automatic t_fill();
        int n;
        sample_valid = 1'b1;
        for (n = 0; n < 40 && sample_ready === 1'b1; n++) begin
            sample_data = 10'(n * 37 + 10'h155);
            @(negedge clk);
        end
        sample_valid = 1'b0;
        check(10'(n), 10'(dac_pkg::FIFO_DEPTH), "fill count");
    endtask
    task automatic t_wake();
        int n;
        shutdown_req = 1'b0;
        run_req = 1'b1;
        wait_mode(dac_pkg::MODE_WAKING, n);
        wait_mode(dac_pkg::MODE_ACTIVE, n);
        check(10'(n), 10'(dac_pkg::WAKE_CYCLES), "wake time");
        check(settled, 1'b1, "settled");
        repeat (4) @(negedge clk);
        check(array_code, 10'(31 * 37 + 10'h155), "last word");
        check(underrun, 1'b1, "underrun");
    endtask
    task automatic t_stream();
        logic [9:0] w [4] = '{10'h3FF, 10'h200, 10'h001, 10'h2AA};
        int n, k;
        fork
            begin
                sample_valid = 1'b1;
                for (n = 0; n < 4; n++) begin
                    sample_data = w[n];
                    @(negedge clk);
                end
                sample_valid = 1'b0;
            end
            begin
                k = 0;
                while (array_code !== w[0] && k < 9) begin
                    @(negedge clk);
                    k++;
                end
                check(underrun, 1'b0, "no underrun");
                for (k = 0; k < 4; k++) begin
                    check(array_code, w[k], "stream word");
                    @(negedge clk);
                end
            end
        join
    endtask
    task automatic t_standby();
        int n;
        run_req = 1'b0;
        wait_mode(dac_pkg::MODE_STANDBY, n);
        check({output_drive_en, array_enable, reference_on, amplifier_on, settled}, 5'b00110, "standby pins");
        run_req = 1'b1;
        wait_mode(dac_pkg::MODE_WAKING, n);
        repeat (2) @(negedge clk);
        check(output_drive_en, 1'b1, "resume drive");
        check(array_code, 10'h2AA, "resume code");
        wait_mode(dac_pkg::MODE_ACTIVE, n);
    endtask
    task automatic t_shutdown();
        int n;
        shutdown_req = 1'b1;
        wait_mode(dac_pkg::MODE_SHUTDOWN, n);
        check({reference_on, amplifier_on, output_drive_en, array_enable}, 4'h0, "shutdown pins");
        shutdown_req = 1'b0;
        wait_mode(dac_pkg::MODE_WAKING, n);
        wait_mode(dac_pkg::MODE_ACTIVE, n);
        check(array_code, 10'h2AA, "after shutdown");
    endtask
    task automatic t_ref();
        check(internal_reference_sel, 1'b1, "internal ref");
        external_ref_req = 1'b1;
        repeat (5) @(negedge clk);
        check({link.reference_enable_n, internal_reference_sel}, 2'b10, "external ref");
        external_ref_req = 1'b0;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(mode, dac_pkg::MODE_SHUTDOWN, "reset mode");
        t_fill();
        t_wake();
        t_stream();
        t_standby();
        t_shutdown();
        t_ref();
        give_verdict();
    end
endmodule
